// ---- src/pcm_out_pkg.sv ----
// constants for the serial pcm output configuration and transmitter
// assumes a parallel register port from the control-bus decoder
// Function
// - bit clock is oversample clock over 2(1+N)
// - 32 or 64 bit clocks per frame
// - 16-bit: oversample equals 2(1+N)*32*Fs
// - wide: oversample equals 2(1+N)*64*Fs
// - bit 6 selects lsb-first shifting
// - bit 5 left/right justification, wide only
// - bit 4 inverts word-select polarity
// - bit 3 alternate framing, cleared by resets
// - bit 2 selects bit-clock launch edge
// - bits 1:0 select sample precision
// - routing: straight, left dup, right dup, swap
// - adpcm codes map to 8/16/32 kHz
// - pll output divider divides by value+1
// - core and host both write pll divider
// - clock mode one holds oversample frequency
// - clock mode zero tracks rate, 256 default
// - fraction bytes concatenate into 16-bit value
package pcm_out_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ADPCM_RATE  = 8'h53;
    localparam logic [7:0] ADDR_BCLK_DIV    = 8'h54;
    localparam logic [7:0] ADDR_PCM_FORMAT  = 8'h55;
    localparam logic [7:0] ADDR_ROUTING     = 8'h56;
    localparam logic [7:0] ADDR_PLL_OUT_DIV = 8'h61;
    localparam logic [7:0] ADDR_CLOCK_MODE  = 8'h63;
    localparam logic [7:0] ADDR_FRAC_LOW    = 8'h64;
    localparam logic [7:0] ADDR_FRAC_HIGH   = 8'h65;
    // reset values
    localparam logic [7:0] RST_ADPCM_RATE   = 8'h00;
    localparam logic [7:0] RST_BCLK_DIV     = 8'h01;
    localparam logic [7:0] RST_PCM_FORMAT   = 8'h21;
    localparam logic [7:0] RST_ROUTING      = 8'h00;
    localparam logic [7:0] RST_PLL_OUT_DIV  = 8'h07;
    localparam logic [7:0] RST_CLOCK_MODE   = 8'h00;
    localparam logic [7:0] RST_FRAC_LOW     = 8'h46;
    localparam logic [7:0] RST_FRAC_HIGH    = 8'h5B;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_ADPCM_RATE  = 8'h1F;
    localparam logic [7:0] MASK_PCM_FORMAT  = 8'h7F;
    localparam logic [7:0] MASK_ROUTING     = 8'h03;
    localparam logic [7:0] MASK_PLL_OUT_DIV = 8'h1F;
    localparam logic [7:0] MASK_CLOCK_MODE  = 8'h01;
    // format field positions
    localparam int FMT_LSB_FIRST = 6;
    localparam int FMT_JUSTIFY   = 5;
    localparam int FMT_POLARITY  = 4;
    localparam int FMT_ALT_FRAME = 3;
    localparam int FMT_LAUNCH    = 2;
    localparam int FMT_WIDTH_HI  = 1;
    // slots per channel half
    localparam logic [6:0] HALF_NARROW = 7'h10;
    localparam logic [6:0] HALF_WIDE   = 7'h20;
    // log2 of 2 * bit clocks per frame, for the oversample factor
    localparam int FACTOR_SHIFT_NARROW = 6;
    localparam int FACTOR_SHIFT_WIDE   = 7;
    // adpcm rate codes and their rates in kHz
    localparam logic [4:0] ADPCM_CODE_8K  = 5'h02;
    localparam logic [4:0] ADPCM_CODE_16K = 5'h0A;
    localparam logic [4:0] ADPCM_CODE_32K = 5'h0E;
    localparam logic [5:0] RATE_8K        = 6'h08;
    localparam logic [5:0] RATE_16K       = 6'h10;
    localparam logic [5:0] RATE_32K       = 6'h20;
    // valid-bit masks for the 24-bit msb-aligned sample
    localparam logic [23:0] KEEP_18 = 24'hFFFFC0;
    localparam logic [23:0] KEEP_20 = 24'hFFFFF0;
    localparam logic [23:0] KEEP_24 = 24'hFFFFFF;
    localparam int SHIFT_18 = 6;
    localparam int SHIFT_20 = 4;
    // routing codes
    typedef enum logic [1:0] {
        ROUTE_STRAIGHT = 2'b00,
        ROUTE_LEFT_DUP = 2'b01,
        ROUTE_RIGHT_DUP = 2'b10,
        ROUTE_SWAP     = 2'b11
    } route_e;
endpackage

// ---- src/pcm_output_config.sv ----
// pcm output configuration registers, clock divider and transmitter
// assumes samples and register strobes come from logic on ref_clk
`timescale 1ns/100ps
module pcm_output_config
    import pcm_out_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    // clock and resets
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  soft_rst,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // decoder core rewrite of the pll output divider
    input  wire logic                  core_div_wr,
    input  wire logic [4:0]            core_div_value,
    // sample stream in
    input  wire logic [SAMPLE_W-1:0]   smp_left,
    input  wire logic [SAMPLE_W-1:0]   smp_right,
    input  wire logic                  smp_valid,
    output logic                       smp_ready,
    // serial link to the dac
    output logic                       serial_bit_clock,
    output logic                       word_select_clock,
    output logic                       serial_data,
    // clock configuration out
    output logic      [15:0]           oversample_factor,
    output logic                       clk_tracks_rate,
    output logic      [4:0]            pll_output_divider,
    output logic      [15:0]           pll_fraction,
    output logic      [5:0]            adpcm_rate_khz
);

////////////////////////////////////////////////////////////////////////
    logic        sreset;
    logic [7:0]  adpcm_rate_select_ff;
    logic [7:0]  bit_clock_divider_reg_ff;
    logic [7:0]  pcm_format_config_ff;
    logic [7:0]  channel_routing_ff;
    logic [7:0]  pll_output_divider_reg_ff;
    logic [7:0]  oversample_clock_mode_ff;
    logic [7:0]  pll_fraction_low_ff;
    logic [7:0]  pll_fraction_high_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  reg_rdata_ff;

    // both hardware and software reset restore the registers
    assign sreset = rst | soft_rst;

    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            adpcm_rate_select_ff     <= RST_ADPCM_RATE;
            bit_clock_divider_reg_ff <= RST_BCLK_DIV;
            pcm_format_config_ff     <= RST_PCM_FORMAT;
            channel_routing_ff       <= RST_ROUTING;
            oversample_clock_mode_ff <= RST_CLOCK_MODE;
            pll_fraction_low_ff      <= RST_FRAC_LOW;
            pll_fraction_high_ff     <= RST_FRAC_HIGH;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_ADPCM_RATE:
                    adpcm_rate_select_ff <= reg_wdata & MASK_ADPCM_RATE;
                ADDR_BCLK_DIV:
                    bit_clock_divider_reg_ff <= reg_wdata;
                ADDR_PCM_FORMAT:
                    pcm_format_config_ff <= reg_wdata & MASK_PCM_FORMAT;
                ADDR_ROUTING:
                    channel_routing_ff <= reg_wdata & MASK_ROUTING;
                ADDR_CLOCK_MODE:
                    oversample_clock_mode_ff <= reg_wdata & MASK_CLOCK_MODE;
                ADDR_FRAC_LOW:
                    pll_fraction_low_ff <= reg_wdata;
                ADDR_FRAC_HIGH:
                    pll_fraction_high_ff <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // core rewrite wins over a host write in the same cycle, and is
    // ignored while the clock mode pins the oversample frequency
    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            pll_output_divider_reg_ff <= RST_PLL_OUT_DIV;
        end else if (core_div_wr && !oversample_clock_mode_ff[0]) begin
            pll_output_divider_reg_ff <= {3'h0, core_div_value};
        end else if (reg_wr && reg_addr == ADDR_PLL_OUT_DIV) begin
            pll_output_divider_reg_ff <= reg_wdata & MASK_PLL_OUT_DIV;
        end
    end

    always_comb begin
        case (reg_addr)
            ADDR_ADPCM_RATE:  nxt_rdata = adpcm_rate_select_ff;
            ADDR_BCLK_DIV:    nxt_rdata = bit_clock_divider_reg_ff;
            ADDR_PCM_FORMAT:  nxt_rdata = pcm_format_config_ff;
            ADDR_ROUTING:     nxt_rdata = channel_routing_ff;
            ADDR_PLL_OUT_DIV: nxt_rdata = pll_output_divider_reg_ff;
            ADDR_CLOCK_MODE:  nxt_rdata = oversample_clock_mode_ff;
            ADDR_FRAC_LOW:    nxt_rdata = pll_fraction_low_ff;
            ADDR_FRAC_HIGH:   nxt_rdata = pll_fraction_high_ff;
            default:          nxt_rdata = 8'h00;
        endcase
    end

    // read data holds until the next read strobe
    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = reg_rdata_ff;

////////////////////////////////////////////////////////////////////////
    logic        lsb_first_select;
    logic        justify_select;
    logic        frame_clock_polarity;
    logic        alt_frame;
    logic        launch_rising;
    logic [1:0]  sample_width;
    logic        wide_mode;
    logic [6:0]  half_len;
    logic [6:0]  last_pos;

    assign lsb_first_select     = pcm_format_config_ff[FMT_LSB_FIRST];
    assign justify_select       = pcm_format_config_ff[FMT_JUSTIFY];
    assign frame_clock_polarity = pcm_format_config_ff[FMT_POLARITY];
    assign alt_frame            = pcm_format_config_ff[FMT_ALT_FRAME];
    assign launch_rising        = pcm_format_config_ff[FMT_LAUNCH];
    assign sample_width = pcm_format_config_ff[FMT_WIDTH_HI -: 2];
    assign wide_mode    = sample_width != 2'b00;
    assign half_len     = wide_mode ? HALF_WIDE : HALF_NARROW;
    assign last_pos     = 7'((half_len << 1) - 7'h01);

    logic [15:0] oversample_factor_ff;
    logic [5:0]  adpcm_rate_khz_ff;
    logic [5:0]  nxt_rate;

    always_comb begin
        case (adpcm_rate_select_ff[4:0])
            ADPCM_CODE_8K:  nxt_rate = RATE_8K;
            ADPCM_CODE_16K: nxt_rate = RATE_16K;
            ADPCM_CODE_32K: nxt_rate = RATE_32K;
            default:        nxt_rate = 6'h00;
        endcase
    end

    // factor = 2(1+N) * bit clocks per frame
    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            oversample_factor_ff <= 16'h0000;
            adpcm_rate_khz_ff    <= 6'h00;
        end else begin
            oversample_factor_ff <= wide_mode
                ? 16'(({8'h00, bit_clock_divider_reg_ff} + 16'h0001)
                      << FACTOR_SHIFT_WIDE)
                : 16'(({8'h00, bit_clock_divider_reg_ff} + 16'h0001)
                      << FACTOR_SHIFT_NARROW);
            adpcm_rate_khz_ff <= nxt_rate;
        end
    end

    assign oversample_factor  = oversample_factor_ff;
    assign clk_tracks_rate    = ~oversample_clock_mode_ff[0];
    assign pll_output_divider = pll_output_divider_reg_ff[4:0];
    assign pll_fraction = {pll_fraction_high_ff, pll_fraction_low_ff};
    assign adpcm_rate_khz     = adpcm_rate_khz_ff;

////////////////////////////////////////////////////////////////////////
    // two-entry buffer: a stalled transmitter back-pressures the source
    logic [2*SAMPLE_W-1:0] buf_mem [2];
    logic                  buf_wr_ptr_ff;
    logic                  buf_rd_ptr_ff;
    logic [1:0]            buf_cnt_ff;
    logic                  buf_valid;
    logic                  buf_push;
    logic                  buf_pop;

    assign smp_ready = buf_cnt_ff != 2'h2;
    assign buf_valid = buf_cnt_ff != 2'h0;
    assign buf_push  = smp_valid & smp_ready;

    always_ff @(posedge ref_clk) begin
        if (buf_push) begin
            buf_mem[buf_wr_ptr_ff] <= {smp_left, smp_right};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            buf_wr_ptr_ff <= 1'b0;
            buf_rd_ptr_ff <= 1'b0;
            buf_cnt_ff    <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_wr_ptr_ff <= ~buf_wr_ptr_ff;
            end
            if (buf_pop) begin
                buf_rd_ptr_ff <= ~buf_rd_ptr_ff;
            end
            buf_cnt_ff <= 2'(buf_cnt_ff + {1'b0, buf_push}
                             - {1'b0, buf_pop});
        end
    end

////////////////////////////////////////////////////////////////////////
    logic [7:0]  div_cnt_ff;
    logic        bclk_ff;
    logic        bclk_toggle;
    logic        launch;

    // ref_clk stands in for the oversample clock
    assign bclk_toggle = div_cnt_ff >= bit_clock_divider_reg_ff;
    assign launch      = bclk_toggle && (~bclk_ff == launch_rising);

    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            div_cnt_ff <= 8'h00;
            bclk_ff    <= 1'b0;
        end else if (bclk_toggle) begin
            div_cnt_ff <= 8'h00;
            bclk_ff    <= ~bclk_ff;
        end else begin
            div_cnt_ff <= 8'(div_cnt_ff + 8'h01);
        end
    end

    logic [6:0]  pos_ff;
    logic [6:0]  nxt_pos;
    logic [6:0]  slot;
    logic [4:0]  slot_bit;
    logic [4:0]  bit_idx;
    logic [31:0] cur_word;
    logic [31:0] cur_left_ff;
    logic [31:0] cur_right_ff;
    logic [31:0] hold_right_ff;
    logic [SAMPLE_W-1:0] pop_left;
    logic [SAMPLE_W-1:0] pop_right;
    logic [SAMPLE_W-1:0] out_left;
    logic [SAMPLE_W-1:0] out_right;
    logic        ws_ff;
    logic        sdata_ff;

    assign nxt_pos = (pos_ff >= last_pos) ? 7'h00 : 7'(pos_ff + 7'h01);
    // standard framing delays data one bit behind word select
    assign slot = alt_frame ? nxt_pos
                : ((nxt_pos == 7'h00) ? last_pos
                                      : 7'(nxt_pos - 7'h01));
    assign cur_word = (slot >= half_len) ? cur_right_ff : cur_left_ff;
    assign slot_bit = 5'((slot >= half_len) ? slot - half_len : slot);
    assign bit_idx  = lsb_first_select
        ? 5'(slot_bit + (wide_mode ? 5'h00 : 5'h10))
        : 5'(5'h1F - slot_bit);
    assign buf_pop  = launch && nxt_pos == last_pos && buf_valid;
    assign {pop_left, pop_right} = buf_mem[buf_rd_ptr_ff];

    always_comb begin
        case (route_e'(channel_routing_ff[1:0]))
            ROUTE_LEFT_DUP:  {out_left, out_right} = {pop_left, pop_left};
            ROUTE_RIGHT_DUP: {out_left, out_right} = {pop_right, pop_right};
            ROUTE_SWAP:      {out_left, out_right} = {pop_right, pop_left};
            default:         {out_left, out_right} = {pop_left, pop_right};
        endcase
    end

    // builds the slot image: narrow keeps the top 16 bits, wide modes
    // mask to precision and justify within the 32-bit slot
    function automatic logic [31:0] slot_image(
        input logic [23:0] smp,
        input logic [1:0]  width,
        input logic        left_aligned
    );
        logic [23:0] kept;
        logic [31:0] img;
        kept = smp;
        img  = 32'h0000_0000;
        case (width)
            2'b00: img = {smp[23:8], 16'h0000};
            2'b01: begin
                kept = smp & KEEP_18;
                img  = left_aligned ? {kept, 8'h00}
                     : ({8'h00, kept} >> SHIFT_18);
            end
            2'b10: begin
                kept = smp & KEEP_20;
                img  = left_aligned ? {kept, 8'h00}
                     : ({8'h00, kept} >> SHIFT_20);
            end
            default: begin
                kept = smp & KEEP_24;
                img  = left_aligned ? {kept, 8'h00} : {8'h00, kept};
            end
        endcase
        return img;
    endfunction

    // left loads one launch before its half, right likewise; an empty
    // buffer sends silence rather than stalling the link
    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            pos_ff        <= 7'h00;
            cur_left_ff   <= 32'h0000_0000;
            cur_right_ff  <= 32'h0000_0000;
            hold_right_ff <= 32'h0000_0000;
            ws_ff         <= 1'b0;
            sdata_ff      <= 1'b0;
        end else if (launch) begin
            pos_ff   <= nxt_pos;
            sdata_ff <= cur_word[bit_idx];
            ws_ff    <= (nxt_pos >= half_len) ^ frame_clock_polarity;
            if (nxt_pos == last_pos) begin
                cur_left_ff <= buf_valid
                    ? slot_image(24'(out_left), sample_width, justify_select)
                    : 32'h0000_0000;
                hold_right_ff <= buf_valid
                    ? slot_image(24'(out_right), sample_width, justify_select)
                    : 32'h0000_0000;
            end
            if (nxt_pos == 7'(half_len - 7'h01)) begin
                cur_right_ff <= hold_right_ff;
            end
        end
    end

    assign serial_bit_clock  = bclk_ff;
    assign word_select_clock = ws_ff;
    assign serial_data       = sdata_ff;

////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sreset);

    logic       prev_bclk_ff;
    logic [8:0] run_ff;
    logic [7:0] div_seen_ff;

    always_ff @(posedge ref_clk) begin
        if (sreset) begin
            prev_bclk_ff <= 1'b0;
            run_ff       <= 9'h000;
            div_seen_ff  <= RST_BCLK_DIV;
        end else begin
            prev_bclk_ff <= bclk_ff;
            run_ff <= (bclk_ff != prev_bclk_ff) ? 9'h001
                                                : 9'(run_ff + 9'h001);
            if (bclk_ff != prev_bclk_ff) begin
                div_seen_ff <= bit_clock_divider_reg_ff;
            end
        end
    end

    chk_bclk_half_period: assert property (
        (bclk_ff != prev_bclk_ff) && run_ff > 9'h001
        && div_seen_ff == bit_clock_divider_reg_ff
        |-> run_ff == 9'({1'b0, bit_clock_divider_reg_ff} + 9'h001))
        else $error("bit clock half period wrong");

    chk_ws_boundary: assert property (
        $changed(ws_ff) && $stable(pcm_format_config_ff)
        && $past(ws_ff ^ frame_clock_polarity) == ($past(pos_ff) >= half_len)
        |-> $past(pos_ff) == $past(7'(half_len - 7'h01))
            || $past(pos_ff) >= $past(last_pos))
        else $error("word select moved off a half boundary");

    chk_factor_value: assert property (
        $stable(bit_clock_divider_reg_ff) && $stable(pcm_format_config_ff)
        |=> oversample_factor == 16'(({8'h00,
            $past(bit_clock_divider_reg_ff)} + 16'h0001)
            * ($past(wide_mode) ? 16'h0080 : 16'h0040)))
        else $error("oversample factor mismatch");

    chk_ws_polarity: assert property (
        launch |=> ws_ff == ((pos_ff >= $past(half_len))
                             ^ $past(frame_clock_polarity)))
        else $error("word select polarity wrong");

    chk_fmt_reset: assert property (
        $fell(sreset) |-> !alt_frame && !launch_rising)
        else $error("format flags not cleared by reset");

    chk_launch_edge: assert property (
        $changed(sdata_ff) && $stable(launch_rising)
        |-> bclk_ff == launch_rising)
        else $error("data changed on the sampling edge");

    chk_adpcm_map: assert property (
        adpcm_rate_select_ff[4:0] == ADPCM_CODE_16K
        |=> adpcm_rate_khz == RATE_16K)
        else $error("adpcm rate decode wrong");

    chk_core_held: assert property (
        core_div_wr && oversample_clock_mode_ff[0] && !reg_wr
        |=> $stable(pll_output_divider))
        else $error("core changed divider in fixed mode");

    chk_core_rewrite: assert property (
        core_div_wr && !oversample_clock_mode_ff[0]
        |=> pll_output_divider == $past(core_div_value))
        else $error("core rewrite of divider lost");

    chk_pop_boundary: assert property (
        buf_pop |=> pos_ff == $past(last_pos) ##1 !buf_pop)
        else $error("buffer popped off frame boundary");

    cov_underrun: cover property (launch && nxt_pos == last_pos && !buf_valid);
    cov_buf_full: cover property (buf_cnt_ff == 2'h2 && smp_valid);
    cov_lsb_wide: cover property (buf_pop && lsb_first_select && wide_mode);
    cov_core_wr:  cover property (core_div_wr && !oversample_clock_mode_ff[0]);
endmodule

// ---- bench/dac_model.sv ----
// serial pcm receiver standing in for the external dac
// assumes the link outputs of pcm_output_config, one word per half
`timescale 1ns/100ps
module dac_model (
    // link from the transmitter
    input  wire logic        bclk,
    input  wire logic        ws,
    input  wire logic        sd,
    // receiver setup
    input  wire logic        fall_sample,
    input  wire logic        alt_frame,
    input  wire logic        narrow,
    // captured words
    output logic      [31:0] got_left,
    output logic      [31:0] got_right,
    output logic      [15:0] frames
);
    logic [31:0] sr_ff;
    logic [31:0] word;
    logic        ws_ff;

    initial frames = 16'h0;
    initial ws_ff = 1'b0;
    initial sr_ff = 32'h0;

    ////////////////////////////////////////////////////////////////////
    // sample on the edge opposite the launch edge
    always @(bclk) begin
        if (bclk !== fall_sample) begin
            // standard framing: old word's lsb lands after ws moves
            word = alt_frame ? sr_ff : {sr_ff[30:0], sd};
            if (narrow)
                word = {16'h0, word[15:0]};
            // word completes when ws toggles, low is left
            if (ws !== ws_ff) begin
                if (ws_ff)
                    got_right <= word;
                else
                    got_left <= word;
                if (ws_ff)
                    frames <= frames + 16'h1;
            end
            sr_ff <= {sr_ff[30:0], sd};
            ws_ff <= ws;
        end
    end
endmodule

// ---- bench/pcm_output_config_tb.sv ----
// self-checking bench for pcm_output_config with a dac model
// assumes the register port and stream contract of the hand-over
`timescale 1ns/100ps
module pcm_output_config_tb;
    import pcm_out_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        soft_rst = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        core_div_wr = 1'b0;
    logic        smp_valid = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [4:0]  core_div_value = 5'h00;
    logic [23:0] smp_left = 24'hA5C312;
    logic [23:0] smp_right = 24'h3C96E1;
    logic        fall_s = 1'b0;
    logic        alt_f = 1'b0;
    logic        nar = 1'b0;
    logic        saw_full = 1'b0;
    logic [7:0]  reg_rdata;
    logic [4:0]  pll_output_divider;
    logic        smp_ready, serial_bit_clock, word_select_clock;
    logic        serial_data, clk_tracks_rate;
    logic [15:0] oversample_factor, pll_fraction, frames;
    logic [5:0]  adpcm_rate_khz;
    logic [31:0] got_left, got_right;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [7:0]  ra [9] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h61, 8'h63,
                            8'h64, 8'h65, 8'h70};
    logic [7:0]  rv [9] = '{8'h00, 8'h01, 8'h21, 8'h00, 8'h07, 8'h00,
                            8'h46, 8'h5B, 8'h00};
    logic [7:0]  mk [9] = '{8'h1F, 8'hFF, 8'h7F, 8'h03, 8'h1F, 8'h01,
                            8'hFF, 8'hFF, 8'h00};
    logic [4:0]  ac [4] = '{5'h02, 5'h0A, 5'h0E, 5'h05};
    logic [5:0]  ak [4] = '{6'h08, 6'h10, 6'h20, 6'h00};
    logic [7:0]  fm [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h18,
                            8'h04, 8'h03, 8'h23};
    logic [7:0]  rt [9] = '{8'h00, 8'h03, 8'h01, 8'h02, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00};
    logic [31:0] el [9] = '{32'hA5C3, 32'h3C96, 32'hA5C3, 32'h3C96,
                            32'hC3A5, 32'h3C96, 32'hA5C3, 32'h00A5C312,
                            32'hA5C31200};
    logic [31:0] er [9] = '{32'h3C96, 32'hA5C3, 32'hA5C3, 32'h3C96,
                            32'h693C, 32'hA5C3, 32'h3C96, 32'h003C96E1,
                            32'h3C96E100};

    always #5 ref_clk = ~ref_clk;

    pcm_output_config DUT (.ref_clk(ref_clk), .rst(rst),
        .soft_rst(soft_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_div_wr(core_div_wr), .core_div_value(core_div_value),
        .smp_left(smp_left), .smp_right(smp_right),
        .smp_valid(smp_valid), .smp_ready(smp_ready),
        .serial_bit_clock(serial_bit_clock),
        .word_select_clock(word_select_clock),
        .serial_data(serial_data), .oversample_factor(oversample_factor),
        .clk_tracks_rate(clk_tracks_rate),
        .pll_output_divider(pll_output_divider),
        .pll_fraction(pll_fraction), .adpcm_rate_khz(adpcm_rate_khz));

    dac_model dac (.bclk(serial_bit_clock), .ws(word_select_clock),
        .sd(serial_data), .fall_sample(fall_s), .alt_frame(alt_f),
        .narrow(nar), .got_left(got_left), .got_right(got_right),
        .frames(frames));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic core(input logic [4:0] v);
        @(posedge ref_clk);
        core_div_value <= v;
        core_div_wr <= 1'b1;
        @(posedge ref_clk);
        core_div_wr <= 1'b0;
        #1;
    endtask

    // bounded wait, the first frames after a change may be torn
    task automatic settle();
        logic [15:0] f0;
        int          k;
        f0 = frames;
        k = 0;
        while (frames - f0 < 16'h3 && k < 20000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk)
        if (smp_valid && smp_ready === 1'b0)
            saw_full <= 1'b1;

    initial begin
        #600000;
        bad_count++;
        give_verdict();
    end

    initial begin
        logic [7:0] d;
        int         n;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd(ra[i], d);
            chk("reset value", 32'(rv[i]), 32'(d));
        end
        for (int i = 0; i < 9; i++) begin
            wr(ra[i], 8'hFF);
            rd(ra[i], d);
            chk("masked value", 32'(mk[i]), 32'(d));
        end
        @(posedge ref_clk) soft_rst <= 1'b1;
        @(posedge ref_clk) soft_rst <= 1'b0;
        rd(ADDR_PCM_FORMAT, d);
        chk("format", 32'(RST_PCM_FORMAT), 32'(d));
        chk("fraction", 32'h5B46, 32'(pll_fraction));
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_ADPCM_RATE, {3'h0, ac[i]});
            repeat (2) @(posedge ref_clk);
            #1;
            chk("adpcm", 32'(ak[i]), 32'(adpcm_rate_khz));
        end
        core(5'h03);
        chk("core div", 32'h3, 32'(pll_output_divider));
        wr(ADDR_CLOCK_MODE, 8'h01);
        core(5'h09);
        chk("fixed div", 32'h3, 32'(pll_output_divider));
        chk("tracks", 32'h0, 32'(clk_tracks_rate));
        wr(ADDR_CLOCK_MODE, 8'h00);
        chk("tracks", 32'h1, 32'(clk_tracks_rate));
        wr(ADDR_PLL_OUT_DIV, 8'h0C);
        chk("host div", 32'hC, 32'(pll_output_divider));
        $display("test clocking done");
        smp_valid <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            // row 5 uses inverted polarity only with alternate framing
            wr(ADDR_PCM_FORMAT, fm[i]);
            wr(ADDR_ROUTING, rt[i]);
            fall_s = fm[i][2];
            alt_f = fm[i][3];
            nar = (fm[i][1:0] == 2'b00);
            settle();
            chk("left", el[i], got_left);
            chk("right", er[i], got_right);
            chk("factor", nar ? 32'd128 : 32'd256,
                32'(oversample_factor));
        end
        wr(ADDR_BCLK_DIV, 8'h03);
        settle();
        chk("factor", 32'd512, 32'(oversample_factor));
        @(posedge serial_bit_clock);
        n = 0;
        while (serial_bit_clock === 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("half period", 32'd4, 32'(n));
        chk("buffer full", 32'h1, 32'(saw_full));
        $display("test stream done");
        give_verdict();
    end
endmodule
